// ===== design/sfcr_consts.svh
/*
 * Constants of the serial flash command decoder: opcodes, phase clock counts,
 * lane positions and reset values. Included by the package and by the top design file.
 */
`ifndef SFCR_CONSTS_SVH
`define SFCR_CONSTS_SVH

// opcodes
`define SFCR_OP_READ 8'h03
`define SFCR_OP_FAST_READ 8'h0B
`define SFCR_OP_RD_SR1 8'h05
`define SFCR_OP_RD_SR2 8'h35
`define SFCR_OP_RD_SR3 8'h15
`define SFCR_OP_WR_SR1 8'h01
`define SFCR_OP_WR_SR2 8'h31
`define SFCR_OP_WR_SR3 8'h11
`define SFCR_OP_ID_SINGLE 8'h90
`define SFCR_OP_ID_DUAL 8'h92
`define SFCR_OP_ID_QUAD 8'h94
`define SFCR_OP_SFDP 8'h5A
`define SFCR_OP_UID 8'h4B
`define SFCR_OP_PROG 8'h02
`define SFCR_OP_DIO_READ 8'hBB
`define SFCR_OP_QIO_READ 8'hEB

// phase lengths in bits or link clocks
`define SFCR_OPC_CLKS 6'd8
`define SFCR_ADDR_BITS 6'd24
`define SFCR_BYTE_BITS 6'd8
`define SFCR_DUMMY_NONE 6'd0
`define SFCR_DUMMY_FAST 6'd8
`define SFCR_DUMMY_ID 6'd4
`define SFCR_DUMMY_SFDP 6'd8
`define SFCR_DUMMY_UID 6'd32
`define SFCR_MODE_DIO 6'd4
`define SFCR_MODE_QIO 6'd2
`define SFCR_DUMMY_QIO 6'd4

// lane counts of a phase digit
`define SFCR_LANES_NONE 3'd0
`define SFCR_LANES_1 3'd1
`define SFCR_LANES_2 3'd2
`define SFCR_LANES_4 3'd4

// pin positions inside the four-lane bus
`define SFCR_PIN_SI 0
`define SFCR_PIN_SO 1

// array address width, printed last byte 1FFFFh
`define SFCR_ARRAY_AW 17

// status register reset values
`define SFCR_SR1_RST 8'h00
`define SFCR_SR2_RST 8'h00
`define SFCR_SR3_RST 8'h00

`endif

// ===== design/sfcr_pkg.sv
/*
 * Types of the serial flash command decoder: state codes, command kinds,
 * the decoded command and the state records of each clock domain.
 * Assumes sfcr_consts.svh on the include path.
 */
`include "sfcr_consts.svh"

package sfcr_pkg;

	typedef enum logic [5:0] {
		ST_OPC = 6'h01,
		ST_ADDR = 6'h02,
		ST_DUMMY = 6'h04,
		ST_DOUT = 6'h08,
		ST_DIN = 6'h10,
		ST_IGNORE = 6'h20
	} sfcr_state_t;

	typedef enum logic [2:0] {
		K_NONE = 3'h0,
		K_ARRAY = 3'h1,
		K_STAT_RD = 3'h2,
		K_STAT_WR = 3'h3,
		K_ID = 3'h4,
		K_SFDP = 3'h5,
		K_UID = 3'h6,
		K_PROG = 3'h7
	} sfcr_kind_t;

	// phase_lane_triple: alanes and dlanes are the address and data digits
	typedef struct packed {
		logic valid;
		sfcr_kind_t kind;
		logic [1:0] sel;
		logic [2:0] alanes;
		logic [5:0] dummy;
		logic [2:0] dlanes;
	} sfcr_cmd_t;

	typedef struct packed {
		sfcr_state_t state;
		logic [5:0] cnt;
		logic [7:0] opc;
		sfcr_cmd_t cmd;
		logic [23:0] addr;
		logic [7:0] sh;
		logic [3:0] io_out;
		logic [3:0] io_oe;
	} sfcr_frame_t;

	typedef struct packed {
		logic [2:0][7:0] sr;
		logic evt_tog;
		logic [1:0] evt_sel;
		logic [7:0] evt_data;
	} sfcr_keep_t;

	typedef struct packed {
		logic tog_seen;
		logic stb;
		logic [1:0] sel;
		logic [7:0] data;
	} sfcr_sys_t;

endpackage

// ===== design/sfcr_sync2.sv
/*
 * Two-flop level synchroniser of parameterised width.
 * Assumes d is a level that stays put for at least two edges of clk.
 */
`timescale 1ns/100ps

module sfcr_sync2 #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic en,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [2*W-1:0] st_q;
	logic [2*W-1:0] st_d;

	// the first stage feeds only the second
	always_comb begin
		st_d = st_q;
		if (en) begin
			st_d = {st_q[W-1:0], d};
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign q = st_q[2*W-1:W];

endmodule

// ===== design/sfcr_array.sv
/*
 * Byte-wide flash array model: one write port, one asynchronous read port.
 * Assumes both ports belong to the link clock domain.
 */
`timescale 1ns/100ps

module sfcr_array #(
	parameter int AW = 17
) (
	input wire logic clk,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [7:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [7:0] rdata
);

	logic [7:0] mem [0:(1<<AW)-1];

	// contents are not reset; an unwritten byte reads unknown
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	assign rdata = mem[raddr];

endmodule

// ===== design/sfcr_top.sv
/*
 * Serial flash command decoder with single, dual and quad lane array read paths.
 * Link side runs on SCK, frame reset by CS_N high and status registers by RST; status write events cross to MCLK.
 * Assumes an SPI mode 0 host that samples on the rising SCK edge.
 */
`timescale 1ns/100ps
`include "sfcr_consts.svh"

module sfcr_top #(
	parameter int AW = `SFCR_ARRAY_AW,
	// identification values are arbitrary
	parameter logic [7:0] MFR_ID = 8'hA5,
	parameter logic [7:0] DEV_ID = 8'h5A,
	parameter logic [63:0] UID_VALUE = 64'h0123456789ABCDEF
) (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic CE,
	input wire logic SCK,
	input wire logic CS_N,
	input wire logic [3:0] IO_I,
	output logic [3:0] IO_O,
	output logic [3:0] IO_OE,
	input wire logic BUSY,
	output logic STAT_WR_STB,
	output logic [1:0] STAT_WR_SEL,
	output logic [7:0] STAT_WR_DATA
);

	localparam sfcr_pkg::sfcr_frame_t FRAME_RST = '{
		state: sfcr_pkg::ST_OPC,
		cnt: 6'h00,
		opc: 8'h00,
		cmd: '0,
		addr: 24'h000000,
		sh: 8'h00,
		io_out: 4'h0,
		io_oe: 4'h0
	};

	sfcr_pkg::sfcr_frame_t frame_q;
	sfcr_pkg::sfcr_frame_t frame_d;
	sfcr_pkg::sfcr_keep_t keep_q;
	sfcr_pkg::sfcr_keep_t keep_d;
	sfcr_pkg::sfcr_sys_t sys_q;
	sfcr_pkg::sfcr_sys_t sys_d;
	sfcr_pkg::sfcr_cmd_t cur_cmd;
	logic [23:0] fetch_addr;
	logic [7:0] src;
	logic [7:0] mem_rdata;
	logic mem_we;
	logic [7:0] mem_wdata;
	logic [1:0] rst_sh_q;
	logic rst_link;
	logic busy_s;
	logic evt_s;
	logic [7:0] din_byte;

	function automatic sfcr_pkg::sfcr_cmd_t mk(input sfcr_pkg::sfcr_kind_t kind,
			input logic [1:0] sel, input logic [2:0] al, input logic [5:0] dm,
			input logic [2:0] dl);
		sfcr_pkg::sfcr_cmd_t c;
		c.valid = 1'b1;
		c.kind = kind;
		c.sel = sel;
		c.alanes = al;
		c.dummy = dm;
		c.dlanes = dl;
		return c;
	endfunction

	// phase_lane_triple of each supported opcode
	function automatic sfcr_pkg::sfcr_cmd_t decode(input logic [7:0] op);
		sfcr_pkg::sfcr_cmd_t c;
		c = '0;
		case (op)
			`SFCR_OP_READ: c = mk(sfcr_pkg::K_ARRAY, 2'd0, `SFCR_LANES_1,
				`SFCR_DUMMY_NONE, `SFCR_LANES_1);
			`SFCR_OP_FAST_READ: c = mk(sfcr_pkg::K_ARRAY, 2'd0, `SFCR_LANES_1,
				`SFCR_DUMMY_FAST, `SFCR_LANES_1);
			`SFCR_OP_RD_SR1: c = mk(sfcr_pkg::K_STAT_RD, 2'd0, `SFCR_LANES_NONE,
				`SFCR_DUMMY_NONE, `SFCR_LANES_1);
			`SFCR_OP_RD_SR2: c = mk(sfcr_pkg::K_STAT_RD, 2'd1, `SFCR_LANES_NONE,
				`SFCR_DUMMY_NONE, `SFCR_LANES_1);
			`SFCR_OP_RD_SR3: c = mk(sfcr_pkg::K_STAT_RD, 2'd2, `SFCR_LANES_NONE,
				`SFCR_DUMMY_NONE, `SFCR_LANES_1);
			`SFCR_OP_WR_SR1: c = mk(sfcr_pkg::K_STAT_WR, 2'd0, `SFCR_LANES_NONE,
				`SFCR_DUMMY_NONE, `SFCR_LANES_1);
			`SFCR_OP_WR_SR2: c = mk(sfcr_pkg::K_STAT_WR, 2'd1, `SFCR_LANES_NONE,
				`SFCR_DUMMY_NONE, `SFCR_LANES_1);
			`SFCR_OP_WR_SR3: c = mk(sfcr_pkg::K_STAT_WR, 2'd2, `SFCR_LANES_NONE,
				`SFCR_DUMMY_NONE, `SFCR_LANES_1);
			`SFCR_OP_ID_SINGLE: c = mk(sfcr_pkg::K_ID, 2'd0, `SFCR_LANES_1,
				`SFCR_DUMMY_NONE, `SFCR_LANES_1);
			`SFCR_OP_ID_DUAL: c = mk(sfcr_pkg::K_ID, 2'd0, `SFCR_LANES_2,
				`SFCR_DUMMY_ID, `SFCR_LANES_2);
			`SFCR_OP_ID_QUAD: c = mk(sfcr_pkg::K_ID, 2'd0, `SFCR_LANES_4,
				`SFCR_DUMMY_ID, `SFCR_LANES_4);
			`SFCR_OP_SFDP: c = mk(sfcr_pkg::K_SFDP, 2'd0, `SFCR_LANES_1,
				`SFCR_DUMMY_SFDP, `SFCR_LANES_1);
			`SFCR_OP_UID: c = mk(sfcr_pkg::K_UID, 2'd0, `SFCR_LANES_NONE,
				`SFCR_DUMMY_UID, `SFCR_LANES_1);
			`SFCR_OP_PROG: c = mk(sfcr_pkg::K_PROG, 2'd0, `SFCR_LANES_1,
				`SFCR_DUMMY_NONE, `SFCR_LANES_1);
			// mode byte is only counted: continuous read is not offered
			`SFCR_OP_DIO_READ: c = mk(sfcr_pkg::K_ARRAY, 2'd0, `SFCR_LANES_2,
				`SFCR_MODE_DIO, `SFCR_LANES_2);
			`SFCR_OP_QIO_READ: c = mk(sfcr_pkg::K_ARRAY, 2'd0, `SFCR_LANES_4,
				`SFCR_MODE_QIO + `SFCR_DUMMY_QIO, `SFCR_LANES_4);
			default: c = '0;
		endcase
		return c;
	endfunction

	// clocks that a field of the given bits takes on the given lanes
	function automatic logic [5:0] lane_clks(input logic [5:0] bits, input logic [2:0] lanes);
		logic [5:0] n;
		n = bits;
		case (lanes)
			`SFCR_LANES_2: n = {1'b0, bits[5:1]};
			`SFCR_LANES_4: n = {2'b00, bits[5:2]};
			default: n = bits;
		endcase
		return n;
	endfunction

	// shift one clock worth of lanes in at the bottom, highest lane as msb
	function automatic logic [23:0] shift_lanes(input logic [23:0] v, input logic [3:0] io,
			input logic [2:0] lanes);
		logic [23:0] r;
		r = {v[22:0], io[`SFCR_PIN_SI]};
		case (lanes)
			`SFCR_LANES_2: r = {v[21:0], io[`SFCR_PIN_SO], io[`SFCR_PIN_SI]};
			`SFCR_LANES_4: r = {v[19:0], io};
			default: r = {v[22:0], io[`SFCR_PIN_SI]};
		endcase
		return r;
	endfunction

	// top bits of a byte placed on the pins; single lane goes out on SO
	function automatic logic [3:0] out_bits(input logic [7:0] b, input logic [2:0] lanes);
		logic [3:0] r;
		r = {2'b00, b[7], 1'b0};
		case (lanes)
			`SFCR_LANES_2: r = {2'b00, b[7], b[6]};
			`SFCR_LANES_4: r = b[7:4];
			default: r = {2'b00, b[7], 1'b0};
		endcase
		return r;
	endfunction

	function automatic logic [3:0] oe_bits(input logic [2:0] lanes);
		logic [3:0] r;
		r = 4'h2;
		case (lanes)
			`SFCR_LANES_2: r = 4'h3;
			`SFCR_LANES_4: r = 4'hF;
			default: r = 4'h2;
		endcase
		return r;
	endfunction

	// enter the data phase; a read puts its first bits out at once
	function automatic sfcr_pkg::sfcr_frame_t start_data(input sfcr_pkg::sfcr_frame_t f,
			input logic [7:0] b);
		sfcr_pkg::sfcr_frame_t r;
		r = f;
		r.cnt = 6'h00;
		if (f.cmd.kind == sfcr_pkg::K_STAT_WR || f.cmd.kind == sfcr_pkg::K_PROG) begin
			r.state = sfcr_pkg::ST_DIN;
		end else begin
			r.state = sfcr_pkg::ST_DOUT;
			r.sh = b;
			r.io_out = out_bits(b, f.cmd.dlanes);
			r.io_oe = oe_bits(f.cmd.dlanes);
			r.addr = f.addr + 24'h000001;
		end
		return r;
	endfunction

	// small discovery table; the signature reads first, unused bytes read FFh
	function automatic logic [7:0] sfdp_byte(input logic [7:0] a);
		logic [7:0] r;
		r = 8'hFF;
		case (a)
			8'h00: r = 8'h53;
			8'h01: r = 8'h46;
			8'h02: r = 8'h44;
			8'h03: r = 8'h50;
			8'h04: r = 8'h06;
			8'h05: r = 8'h01;
			8'h06: r = 8'h00;
			default: r = 8'hFF;
		endcase
		return r;
	endfunction

	// reset bridge: RST asserts the link reset at once, release waits two SCK edges
	always_ff @(posedge SCK or posedge RST) begin
		if (RST) begin
			rst_sh_q <= 2'b11;
		end else begin
			rst_sh_q <= {rst_sh_q[0], 1'b0};
		end
	end
	assign rst_link = rst_sh_q[1];

	sfcr_sync2 #(
		.W(1)
	) u_busy_sync (
		.clk(SCK),
		.rst(1'b0),
		.en(1'b1),
		.d(BUSY),
		.q(busy_s)
	);

	sfcr_array #(
		.AW(AW)
	) u_array (
		.clk(SCK),
		.we(mem_we),
		.waddr(frame_q.addr[AW-1:0]),
		.wdata(mem_wdata),
		.raddr(fetch_addr[AW-1:0]),
		.rdata(mem_rdata)
	);

	// during the opcode phase the command is still being decoded
	assign cur_cmd = (frame_q.state == sfcr_pkg::ST_OPC) ?
		decode({frame_q.opc[6:0], IO_I[`SFCR_PIN_SI]}) : frame_q.cmd;
	assign fetch_addr = (frame_q.state == sfcr_pkg::ST_ADDR) ?
		shift_lanes(frame_q.addr, IO_I, frame_q.cmd.alanes) : frame_q.addr;
	assign din_byte = {frame_q.sh[6:0], IO_I[`SFCR_PIN_SI]};

	// byte that the next data phase clock will start to send
	always_comb begin
		src = 8'hFF;
		unique case (cur_cmd.kind)
			sfcr_pkg::K_NONE: src = 8'hFF;
			sfcr_pkg::K_ARRAY: src = mem_rdata;
			sfcr_pkg::K_PROG: src = mem_rdata;
			sfcr_pkg::K_STAT_RD: begin
				src = keep_q.sr[cur_cmd.sel];
				if (cur_cmd.sel == 2'd0) begin
					src = {keep_q.sr[0][7:1], busy_s};
				end
			end
			sfcr_pkg::K_STAT_WR: src = 8'hFF;
			sfcr_pkg::K_ID: src = fetch_addr[0] ? DEV_ID : MFR_ID;
			sfcr_pkg::K_SFDP: src = sfdp_byte(fetch_addr[7:0]);
			sfcr_pkg::K_UID: src = UID_VALUE[{~fetch_addr[2:0], 3'b000} +: 8];
		endcase
	end

	always_comb begin
		frame_d = frame_q;
		keep_d = keep_q;
		mem_we = 1'b0;
		mem_wdata = din_byte;
		unique case (frame_q.state)
			sfcr_pkg::ST_OPC: begin
				frame_d.opc = {frame_q.opc[6:0], IO_I[`SFCR_PIN_SI]};
				frame_d.cnt = frame_q.cnt + 6'd1;
				if (frame_q.cnt == `SFCR_OPC_CLKS - 6'd1) begin
					frame_d.cnt = 6'h00;
					frame_d.cmd = cur_cmd;
					if (!cur_cmd.valid) begin
						frame_d.state = sfcr_pkg::ST_IGNORE;
					end else if (cur_cmd.alanes != `SFCR_LANES_NONE) begin
						frame_d.state = sfcr_pkg::ST_ADDR;
					end else if (cur_cmd.dummy != `SFCR_DUMMY_NONE) begin
						frame_d.state = sfcr_pkg::ST_DUMMY;
					end else begin
						frame_d = start_data(frame_d, src);
					end
				end
			end
			sfcr_pkg::ST_ADDR: begin
				frame_d.addr = fetch_addr;
				frame_d.cnt = frame_q.cnt + 6'd1;
				if (frame_q.cnt == lane_clks(`SFCR_ADDR_BITS, frame_q.cmd.alanes) - 6'd1) begin
					frame_d.cnt = 6'h00;
					if (frame_q.cmd.dummy != `SFCR_DUMMY_NONE) begin
						frame_d.state = sfcr_pkg::ST_DUMMY;
					end else begin
						frame_d = start_data(frame_d, src);
					end
				end
			end
			sfcr_pkg::ST_DUMMY: begin
				// pins are not looked at: only the clocks count
				frame_d.cnt = frame_q.cnt + 6'd1;
				if (frame_q.cnt == frame_q.cmd.dummy - 6'd1) begin
					frame_d = start_data(frame_q, src);
				end
			end
			sfcr_pkg::ST_DOUT: begin
				frame_d.cnt = frame_q.cnt + 6'd1;
				if (frame_q.cnt == lane_clks(`SFCR_BYTE_BITS, frame_q.cmd.dlanes) - 6'd1) begin
					// next byte follows with no gap, also across the array end
					frame_d.cnt = 6'h00;
					frame_d.sh = src;
					frame_d.io_out = out_bits(src, frame_q.cmd.dlanes);
					frame_d.addr = frame_q.addr + 24'h000001;
				end else begin
					frame_d.sh = frame_q.sh << frame_q.cmd.dlanes;
					frame_d.io_out = out_bits(frame_d.sh, frame_q.cmd.dlanes);
				end
			end
			sfcr_pkg::ST_DIN: begin
				frame_d.sh = din_byte;
				frame_d.cnt = frame_q.cnt + 6'd1;
				if (frame_q.cnt == `SFCR_BYTE_BITS - 6'd1) begin
					frame_d.cnt = 6'h00;
					if (frame_q.cmd.kind == sfcr_pkg::K_STAT_WR) begin
						// exactly one byte; later clocks are ignored
						frame_d.state = sfcr_pkg::ST_IGNORE;
						keep_d.sr[frame_q.cmd.sel] = din_byte;
						keep_d.evt_tog = ~keep_q.evt_tog;
						keep_d.evt_sel = frame_q.cmd.sel;
						keep_d.evt_data = din_byte;
					end else begin
						mem_we = 1'b1;
						frame_d.addr = frame_q.addr + 24'h000001;
					end
				end
			end
			sfcr_pkg::ST_IGNORE: begin
				frame_d = frame_q;
			end
		endcase
	end

	// CS_N high clears the frame at once, mid-byte included, and floats the pins
	always_ff @(posedge SCK or posedge CS_N) begin
		if (CS_N) begin
			frame_q <= FRAME_RST;
		end else begin
			frame_q <= frame_d;
		end
	end

	always_ff @(posedge SCK or posedge rst_link) begin
		if (rst_link) begin
			keep_q <= '{
				sr: {`SFCR_SR3_RST, `SFCR_SR2_RST, `SFCR_SR1_RST},
				evt_tog: 1'b0,
				evt_sel: 2'b00,
				evt_data: 8'h00
			};
		end else begin
			keep_q <= keep_d;
		end
	end

	// status write event: toggle crosses, the held word is read once it has settled
	sfcr_sync2 #(
		.W(1)
	) u_evt_sync (
		.clk(MCLK),
		.rst(RST),
		.en(CE),
		.d(keep_q.evt_tog),
		.q(evt_s)
	);

	always_comb begin
		sys_d = sys_q;
		sys_d.stb = 1'b0;
		if (evt_s != sys_q.tog_seen) begin
			sys_d.tog_seen = evt_s;
			sys_d.stb = 1'b1;
			sys_d.sel = keep_q.evt_sel;
			sys_d.data = keep_q.evt_data;
		end
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			sys_q <= '0;
		end else if (CE) begin
			sys_q <= sys_d;
		end
	end

	assign IO_O = frame_q.io_out;
	assign IO_OE = frame_q.io_oe;
	assign STAT_WR_STB = sys_q.stb;
	assign STAT_WR_SEL = sys_q.sel;
	assign STAT_WR_DATA = sys_q.data;

endmodule

// ===== tb/sfcr_top_monitor.sv
/*
 * Concurrent checks on the ports of the command decoder top.
 * Assumes it is bound to sfcr_top; link checks run on SCK and stop while CS_N is high.
 */
`timescale 1ns/100ps
`include "sfcr_consts.svh"

module sfcr_top_monitor (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic SCK,
	input wire logic CS_N,
	input wire logic [3:0] IO_I,
	input wire logic [3:0] IO_OE,
	input wire logic STAT_WR_STB
);
	logic [5:0] cnt_q;
	logic [7:0] opc_q;
	logic known;

	// rises seen in this frame, saturating so long streams stay in the last phase
	always_ff @(posedge SCK or posedge CS_N) begin
		if (CS_N) begin
			cnt_q <= 6'h00;
			opc_q <= 8'h00;
		end else begin
			if (cnt_q != 6'h3F) cnt_q <= cnt_q + 6'h01;
			if (cnt_q < 6'h08) opc_q <= {opc_q[6:0], IO_I[`SFCR_PIN_SI]};
		end
	end

	assign known = opc_q inside {`SFCR_OP_READ, `SFCR_OP_FAST_READ, `SFCR_OP_RD_SR1,
		`SFCR_OP_RD_SR2, `SFCR_OP_RD_SR3, `SFCR_OP_WR_SR1, `SFCR_OP_WR_SR2,
		`SFCR_OP_WR_SR3, `SFCR_OP_ID_SINGLE, `SFCR_OP_ID_DUAL, `SFCR_OP_ID_QUAD,
		`SFCR_OP_SFDP, `SFCR_OP_UID, `SFCR_OP_PROG, `SFCR_OP_DIO_READ, `SFCR_OP_QIO_READ};

	chk_oe_cs_high: assert property (@(posedge MCLK) disable iff (RST)
		CS_N |-> IO_OE == 4'h0) else $error("output enabled while deselected");
	chk_stb_one_cycle: assert property (@(posedge MCLK) disable iff (RST)
		STAT_WR_STB |=> !STAT_WR_STB) else $error("status strobe longer than one cycle");
	chk_opc_quiet: assert property (@(posedge SCK) disable iff (CS_N)
		cnt_q < 6'h08 |-> IO_OE == 4'h0) else $error("output driven during opcode");
	chk_unknown_quiet: assert property (@(posedge SCK) disable iff (CS_N)
		(cnt_q >= 6'h08 && !known) |-> IO_OE == 4'h0) else $error("unknown opcode drove output");
	chk_status_read: assert property (@(posedge SCK) disable iff (CS_N)
		(cnt_q >= 6'h08 && opc_q inside {`SFCR_OP_RD_SR1, `SFCR_OP_RD_SR2, `SFCR_OP_RD_SR3})
		|-> IO_OE == 4'h2) else $error("status read not driven after opcode");
	chk_status_write: assert property (@(posedge SCK) disable iff (CS_N)
		opc_q inside {`SFCR_OP_WR_SR1, `SFCR_OP_WR_SR2, `SFCR_OP_WR_SR3} |-> IO_OE == 4'h0)
		else $error("status write drove output");
	chk_plain_read: assert property (@(posedge SCK) disable iff (CS_N)
		(cnt_q >= 6'h08 && opc_q == `SFCR_OP_READ) |-> IO_OE == (cnt_q >= 6'h20 ? 4'h2 : 4'h0))
		else $error("plain read data start wrong");
	chk_fast_read: assert property (@(posedge SCK) disable iff (CS_N)
		(cnt_q >= 6'h08 && opc_q == `SFCR_OP_FAST_READ)
		|-> IO_OE == (cnt_q >= 6'h28 ? 4'h2 : 4'h0)) else $error("fast read data start wrong");
	chk_dual_id: assert property (@(posedge SCK) disable iff (CS_N)
		(cnt_q >= 6'h08 && opc_q == `SFCR_OP_ID_DUAL)
		|-> IO_OE == (cnt_q >= 6'h18 ? 4'h3 : 4'h0)) else $error("dual id timing wrong");
	chk_quad_id: assert property (@(posedge SCK) disable iff (CS_N)
		(cnt_q >= 6'h08 && opc_q == `SFCR_OP_ID_QUAD)
		|-> IO_OE == (cnt_q >= 6'h12 ? 4'hF : 4'h0)) else $error("quad id timing wrong");
endmodule

// ===== tb/sfcr_host_model.sv
/*
 * Host controller model: mode 0 frames on SCK, CS_N and the four lanes.
 * Assumes the device updates on the rising edge; the host samples mid high phase.
 */
`timescale 1ns/100ps

module sfcr_host_model (
	output logic SCK,
	output logic CS_N,
	output logic [3:0] IO_I,
	input wire logic [3:0] IO_O,
	input wire logic [3:0] IO_OE
);
	logic [3:0] hv;

	initial begin
		SCK = 1'b0;
		CS_N = 1'b0;
		hv = 4'hF;
		// a definite rising edge, so the frame logic is reset from the start
		#1 CS_N = 1'b1;
	end

	// the device wins a lane it enables; the host value shows elsewhere
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			IO_I[i] = IO_OE[i] ? IO_O[i] : hv[i];
		end
	end

	task automatic frame(input logic [7:0] opc, input logic [63:0] tx, input int txn,
		input int ln, input int nd, input int nrx, input int cut,
		output logic [31:0] rx, output logic oe_any);
		int n;
		int tot;
		logic [71:0] sh;
		n = 8 + txn / ln + nd;
		tot = (nrx > 0) ? n + nrx / ln - 1 : n;
		if (cut > 0) tot = cut;
		sh = {opc, tx << (64 - txn)};
		rx = '0;
		oe_any = 1'b0;
		#37 CS_N = 1'b0;
		for (int c = 1; c <= tot; c++) begin
			if (c <= 8 || (c <= 8 + txn / ln && ln == 1)) begin
				hv = {3'b111, sh[71]};
				sh = sh << 1;
			end else if (c <= 8 + txn / ln) begin
				hv = (ln == 2) ? {2'b11, sh[71:70]} : sh[71:68];
				sh = sh << ln;
			end else begin
				// released lanes toggle so a stale level cannot pass for data
				hv = ~hv;
			end
			#80 SCK = 1'b1;
			#40;
			if (c >= n) begin
				case (ln)
					1: rx = {rx[30:0], IO_O[1]};
					2: rx = {rx[29:0], IO_O[1:0]};
					default: rx = {rx[27:0], IO_O};
				endcase
			end
			oe_any = oe_any | (|IO_OE);
			#40 SCK = 1'b0;
		end
		#80 CS_N = 1'b1;
		hv = ~hv;
		#40;
	endtask
endmodule

// ===== tb/tb.sv
/*
 * Bench of the command decoder: status, array, id and table reads over the link.
 * Assumes the host model drives the link and the monitor is bound to the top.
 */
`timescale 1ns/100ps
`include "sfcr_consts.svh"

module tb;
	// identification values are arbitrary
	localparam logic [7:0] MFR = 8'h3C;
	localparam logic [7:0] DEV = 8'hC3;
	localparam logic [63:0] UID = 64'h1122334455667788;
	logic MCLK, RST, CE, BUSY, SCK, CS_N, STAT_WR_STB, oe;
	logic [3:0] IO_I, IO_O, IO_OE;
	logic [1:0] STAT_WR_SEL, stb_sel;
	logic [7:0] STAT_WR_DATA, stb_dat;
	logic [31:0] rx;
	int num_errors = 0;
	int n_compared = 0;
	int stb_n = 0;

	// narrow array so the wrap at the last byte is reachable
	sfcr_top #(.AW(8), .MFR_ID(MFR), .DEV_ID(DEV), .UID_VALUE(UID)) dut (.MCLK(MCLK),
		.RST(RST), .CE(CE), .SCK(SCK), .CS_N(CS_N), .IO_I(IO_I), .IO_O(IO_O),
		.IO_OE(IO_OE), .BUSY(BUSY), .STAT_WR_STB(STAT_WR_STB),
		.STAT_WR_SEL(STAT_WR_SEL), .STAT_WR_DATA(STAT_WR_DATA));
	sfcr_host_model host (.SCK(SCK), .CS_N(CS_N), .IO_I(IO_I), .IO_O(IO_O), .IO_OE(IO_OE));

	initial begin
		MCLK = 1'b0;
		forever #5 MCLK = ~MCLK;
	end

	always @(posedge MCLK) begin
		if (STAT_WR_STB === 1'b1) begin
			stb_n++;
			stb_sel = STAT_WR_SEL;
			stb_dat = STAT_WR_DATA;
		end
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic rd(input logic [7:0] opc, input logic [63:0] tx, input int txn, input int ln,
		input int nd, input int nrx, input logic [31:0] exp);
		host.frame(opc, tx, txn, ln, nd, nrx, 0, rx, oe);
		check($sformatf("read %h", opc), rx, exp);
	endtask

	task automatic t_status();
		logic [7:0] v[3];
		logic [7:0] wop[3];
		logic [7:0] rop[3];
		v = '{8'h5C, 8'hA6, 8'h3F};
		wop = '{`SFCR_OP_WR_SR1, `SFCR_OP_WR_SR2, `SFCR_OP_WR_SR3};
		rop = '{`SFCR_OP_RD_SR1, `SFCR_OP_RD_SR2, `SFCR_OP_RD_SR3};
		for (int i = 0; i < 3; i++) begin
			rd(rop[i], 0, 0, 1, 0, 8, 32'h0);
			host.frame(wop[i], v[i], 8, 1, 0, 0, 0, rx, oe);
			repeat (10) @(posedge MCLK);
			check("strobe count", 32'(stb_n), 32'(i + 1));
			check("strobe sel", 32'(stb_sel), 32'(i));
			check("strobe data", 32'(stb_dat), 32'(v[i]));
			check("write output", 32'(oe), 32'h0);
			rd(rop[i], 0, 0, 1, 0, 16, {16'h0, v[i], v[i]});
		end
		@(negedge MCLK) BUSY = 1'b1;
		rd(rop[0], 0, 0, 1, 0, 8, 32'(v[0] | 8'h01));
		// opcode plus five data bits, then deselect
		host.frame(wop[1], 8'hFF, 8, 1, 0, 0, 13, rx, oe);
		repeat (10) @(posedge MCLK);
		check("partial write strobe", 32'(stb_n), 32'd3);
		rd(rop[1], 0, 0, 1, 0, 8, 32'hA6);
		// a frozen system side must hold the event back until enabled again
		@(negedge MCLK) CE = 1'b0;
		host.frame(wop[2], v[2], 8, 1, 0, 0, 0, rx, oe);
		check("frozen strobe", 32'(stb_n), 32'd3);
		@(negedge MCLK) CE = 1'b1;
		repeat (10) @(posedge MCLK);
		check("released strobe", 32'(stb_n), 32'd4);
		check("released data", 32'(stb_dat), 32'(v[2]));
		$display("done status");
	endtask

	task automatic t_array();
		host.frame(`SFCR_OP_PROG, {24'hFFFFFE, 16'h9E7F}, 40, 1, 0, 0, 0, rx, oe);
		host.frame(`SFCR_OP_PROG, {24'hE00000, 16'h01C8}, 40, 1, 0, 0, 0, rx, oe);
		rd(`SFCR_OP_READ, 24'h1234FE, 24, 1, 0, 32, 32'h9E7F01C8);
		rd(`SFCR_OP_FAST_READ, 24'h0000FF, 24, 1, 8, 16, 32'h7F01);
		rd(`SFCR_OP_DIO_READ, 24'h0000FE, 24, 2, 4, 16, 32'h9E7F);
		rd(`SFCR_OP_QIO_READ, 24'h0000FF, 24, 4, 6, 16, 32'h7F01);
		host.frame(`SFCR_OP_READ, 24'h0, 24, 1, 0, 12, 0, rx, oe);
		check("cut read", rx, 32'h01C);
		check("cut release", 32'(IO_OE), 32'h0);
		$display("done array");
	endtask

	task automatic t_ids();
		rd(`SFCR_OP_ID_SINGLE, 0, 24, 1, 0, 16, {16'h0, MFR, DEV});
		rd(`SFCR_OP_ID_DUAL, 1, 24, 2, 4, 16, {16'h0, DEV, MFR});
		rd(`SFCR_OP_ID_QUAD, 0, 24, 4, 4, 16, {16'h0, MFR, DEV});
		rd(`SFCR_OP_SFDP, 0, 24, 1, 8, 16, 32'h5346);
		rd(`SFCR_OP_UID, 0, 0, 1, 32, 16, {16'h0, UID[63:48]});
		host.frame(8'h9F, 0, 24, 1, 0, 16, 0, rx, oe);
		check("unknown output", 32'(oe), 32'h0);
		rd(`SFCR_OP_RD_SR2, 0, 0, 1, 0, 8, 32'hA6);
		$display("done ids");
	endtask

	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		#400000;
		num_errors++;
		$display("watchdog expired");
		close_out();
	end

	initial begin
		RST = 1'b0;
		CE = 1'b1;
		BUSY = 1'b0;
		// raise reset on a real edge so the link side reset sees it
		@(posedge MCLK);
		@(negedge MCLK) RST = 1'b1;
		repeat (12) @(posedge MCLK);
		@(negedge MCLK) RST = 1'b0;
		t_status();
		t_array();
		t_ids();
		close_out();
	end
endmodule

bind sfcr_top sfcr_top_monitor u_mon (.MCLK(MCLK), .RST(RST), .SCK(SCK), .CS_N(CS_N),
	.IO_I(IO_I), .IO_OE(IO_OE), .STAT_WR_STB(STAT_WR_STB));
